// file: verif/edc_ctrl_properties.sv
// Checker on the controller's strobe and data pins
`timescale 1ns/1ps
`default_nettype none
module edc_chk #(
  parameter int unsigned POWERUP_CYC = 40000, // Pause
  parameter int unsigned REFRESH_INT_CYC = 3125 // Interval
) (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic init_done, // Wake-up over
  input wire logic row_strobe_n, // Row strobe
  input wire logic low_col_strobe_n, // Low strobe
  input wire logic high_col_strobe_n, // High strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic output_gate_n, // Output gate
  input wire logic data_pins_oe // Data drive
);
  int unsigned lo_n, hi_n, up_n, gap_n;
  wire cas_n = low_col_strobe_n & high_col_strobe_n;
  // Phase counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lo_n <= 0;
      hi_n <= 0;
      up_n <= 0;
      gap_n <= 0;
    end else begin
      lo_n <= row_strobe_n ? 0 : lo_n + 1;
      hi_n <= row_strobe_n ? hi_n + 1 : 0;
      up_n <= up_n + 1;
      gap_n <= ($fell(row_strobe_n) && !cas_n) ? 0 : gap_n + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rfr_s;
    $fell(row_strobe_n) && !cas_n;
  endsequence
  sequence col_s;
    $fell(cas_n) && !row_strobe_n;
  endsequence
  ras_min_a: assert property ($rose(row_strobe_n) |-> lo_n >= edc_pkg::RAS_CYC)
    else $error("row strobe pulse short");
  precharge_a: assert property ($fell(row_strobe_n) |-> hi_n >= edc_pkg::RP_CYC)
    else $error("precharge short");
  row_first_a: assert property (col_s |-> lo_n >= edc_pkg::RCD_CYC)
    else $error("column before row settled");
  write_data_a: assert property (!write_strobe_n && !cas_n && !row_strobe_n |-> data_pins_oe)
    else $error("write without data");
  read_we_a: assert property (!output_gate_n |-> write_strobe_n && !data_pins_oe)
    else $error("read with write strobe or drive");
  rfr_quiet_a: assert property (rfr_s |-> output_gate_n && !data_pins_oe)
    else $error("refresh with data access");
  powerup_a: assert property ($fell(row_strobe_n) |-> up_n >= POWERUP_CYC)
    else $error("row strobe during pause");
  refresh_gap_a: assert property (init_done |-> gap_n <= 2 * REFRESH_INT_CYC)
    else $error("refresh overdue");
endmodule
bind edc_ctrl edc_chk #(.POWERUP_CYC(POWERUP_CYC), .REFRESH_INT_CYC(REFRESH_INT_CYC)) chk (
  .clk(clk), .resetn(resetn), .init_done(init_done), .row_strobe_n(row_strobe_n),
  .low_col_strobe_n(low_col_strobe_n), .high_col_strobe_n(high_col_strobe_n),
  .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n), .data_pins_oe(data_pins_oe));
`default_nettype wire

// file: verif/edc_dram_model.sv
// Behavioural model of the memory device on the far side
`timescale 1ns/1ps
`default_nettype none
module edc_dram_model (
  input wire logic row_strobe_n, // Row strobe
  input wire logic low_col_strobe_n, // Low strobe
  input wire logic high_col_strobe_n, // High strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic output_gate_n, // Output gate
  input wire logic [8:0] mux_address_pins, // Address
  input wire logic [15:0] data_pins_out, // Write data
  input wire logic data_pins_oe, // Controller drives
  output logic [15:0] data_pins_in // Pin level
);
  logic [15:0] mem [0:262143];
  logic [8:0] row, col, rfc;
  logic [1:0] ln;
  logic [15:0] q;
  logic ctr_rfr, early, ras_ok, cas_ok;
  int rfr_cnt;
  wire cas_n = low_col_strobe_n & high_col_strobe_n;
  wire rd_on = !row_strobe_n && !ctr_rfr && !early && !output_gate_n && write_strobe_n;
  wire [15:0] m = {{8{ln[1]}}, {8{ln[0]}}} & {16{rd_on && ras_ok && cas_ok}};
  // Lanes not driven show the inverse of the held word
  assign data_pins_in = data_pins_oe ? data_pins_out : (q & m) | (~q & ~m);
  initial begin
    {ctr_rfr, early, ras_ok, cas_ok} = 4'h4;
    ln = 2'h0;
    q = 16'h0;
    rfc = 9'h0;
    rfr_cnt = 0;
  end
  // Row strobe fall: counter refresh or row capture, after the edge's pin updates settle
  always @(negedge row_strobe_n) begin
    #0.1;
    ctr_rfr = !cas_n;
    if (ctr_rfr) begin
      rfc = rfc + 9'h1;
      rfr_cnt++;
    end else begin
      row = mux_address_pins;
    end
    ras_ok <= #35 1'b1;
  end
  always @(posedge row_strobe_n) begin
    ras_ok = 1'b0;
    ctr_rfr = 1'b0;
  end
  // Column strobe fall inside an open row; address and lanes read once settled
  always @(negedge cas_n) begin
    #0.1;
    if (!row_strobe_n && !ctr_rfr) begin
      col = mux_address_pins;
      ln = ~{high_col_strobe_n, low_col_strobe_n};
      early = !write_strobe_n;
      q = mem[{row, col}];
      cas_ok = 1'b0;
      cas_ok <= #11 1'b1;
    end
  end
  // Write lands at the later strobe fall
  always @(negedge cas_n or negedge write_strobe_n) begin
    #0.2;
    if (!row_strobe_n && !ctr_rfr && !cas_n && !write_strobe_n) begin
      if (!low_col_strobe_n) mem[{row, col}][7:0] = data_pins_in[7:0];
      if (!high_col_strobe_n) mem[{row, col}][15:8] = data_pins_in[15:8];
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench: controller against the memory model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic w;
    logic [15:0] m;
    logic [15:0] d;
  } edc_note_t;
  logic clk, resetn, req_valid, req_ready, rsp_valid, init_done;
  logic rs_n, lc_n, hc_n, we_n, og_n, oe;
  logic [8:0] ma;
  logic [15:0] dout, din;
  logic [15:0] shadow [int];
  logic [17:0] a;
  edc_pkg::edc_req_t req;
  edc_pkg::edc_rsp_t rsp;
  edc_note_t notes [$];
  edc_note_t nt;
  int failures, tests_run, rfr0;
  edc_ctrl #(.POWERUP_CYC(20), .REFRESH_INT_CYC(200)) uut (
    .clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done), .row_strobe_n(rs_n),
    .low_col_strobe_n(lc_n), .high_col_strobe_n(hc_n), .write_strobe_n(we_n), .output_gate_n(og_n),
    .mux_address_pins(ma), .data_pins_out(dout), .data_pins_oe(oe), .data_pins_in(din));
  edc_dram_model mdl (
    .row_strobe_n(rs_n), .low_col_strobe_n(lc_n), .high_col_strobe_n(hc_n), .write_strobe_n(we_n),
    .output_gate_n(og_n), .mux_address_pins(ma), .data_pins_out(dout), .data_pins_oe(oe),
    .data_pins_in(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check_rd(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic check_flag(input logic exp, input logic got);
    check_rd({15'h0, exp}, {15'h0, got});
  endtask
  // One request: hold until taken, then wait for its completion
  task automatic xfer(input logic w, input logic [1:0] ln, input logic [17:0] ad, input logic [15:0] d);
    logic [15:0] m;
    int n;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    if (!shadow.exists(ad)) shadow[ad] = 16'h0;
    if (w) shadow[ad] = (shadow[ad] & ~m) | (d & m);
    notes.push_back('{w, m, shadow[ad]});
    req <= '{w, ln, ad, d};
    req_valid <= 1'b1;
    n = 0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 3000);
    req_valid <= 1'b0;
    check_flag(1'b1, n < 3000);
    n = 0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 100);
    check_flag(1'b1, n < 100);
  endtask
  // Result watcher
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) check_flag(1'b0, 1'b1);
      else begin
        nt = notes.pop_front();
        if (!nt.w) check_rd(nt.d & nt.m, rsp.rdata & nt.m);
      end
    end
  end
  task automatic start(input int base);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 2000 && init_done !== 1'b1; i++) @(posedge clk);
    check_flag(1'b1, init_done);
    check_flag(1'b1, mdl.rfr_cnt >= base + 8);
  endtask
  task summarize;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(32'h813a));
    start(0);
    // Rows 0 and 511 in runs of four; full word, byte lanes, read back
    for (int i = 0; i < 24; i++) begin
      a = {i[2] ? 9'h1ff : 9'h000, i < 2 ? {9{i[0]}} : 9'($urandom)};
      xfer(1'b1, 2'h3, a, 16'($urandom));
      xfer(1'b1, 2'($urandom_range(1, 3)), a, 16'($urandom));
      xfer(1'b0, 2'($urandom_range(1, 3)), a, 16'h0);
    end
    // Idle across refresh intervals, data must survive
    rfr0 = mdl.rfr_cnt;
    repeat (1000) @(posedge clk);
    check_flag(1'b1, mdl.rfr_cnt - rfr0 >= 4);
    foreach (shadow[k]) xfer(1'b0, 2'h3, 18'(k), 16'h0);
    // Second reset in mid-run repeats the wake-up
    start(mdl.rfr_cnt);
    summarize();
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire

// file: verilog/edc_ctrl.sv
// Dynamic memory controller: power-up, counter refresh, read/write with open-row page mode
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl #(
  parameter int unsigned POWERUP_CYC = edc_pkg::POWERUP_CYC, // Power-up pause
  parameter int unsigned REFRESH_INT_CYC = edc_pkg::REFRESH_INT_CYC // Per-row refresh interval
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic req_valid, // User request present
  input wire edc_pkg::edc_req_t req, // User request fields
  output logic req_ready, // Request taken this cycle
  output logic rsp_valid, // One-cycle done pulse
  output edc_pkg::edc_rsp_t rsp, // Read data
  output logic init_done, // Wake-up sequence finished
  output logic row_strobe_n, // Row strobe
  output logic low_col_strobe_n, // Low lane column strobe
  output logic high_col_strobe_n, // High lane column strobe
  output logic write_strobe_n, // Write strobe
  output logic output_gate_n, // Output gate
  output logic [edc_pkg::ROW_W-1:0] mux_address_pins, // Row/column address
  output logic [edc_pkg::DATA_W-1:0] data_pins_out, // Write data to pins
  output logic data_pins_oe, // High while driving data pins
  input wire logic [edc_pkg::DATA_W-1:0] data_pins_in // Data pins level
);
  localparam int unsigned CW = edc_pkg::CNT_W;
  localparam int unsigned RW = edc_pkg::ROW_W;

  typedef enum logic [3:0] {
    S_POWERUP, S_IDLE, S_RFR_SETUP, S_RFR_ACTIVE, S_PRECHARGE,
    S_ROW_OPEN, S_COL_SETUP, S_COL_ACTIVE, S_COL_PRE
  } edc_state_t;

  edc_state_t state;
  edc_state_t next_state;
  logic [CW-1:0] tim_count;
  logic tim_load;
  logic tim_done;
  logic [CW-1:0] ras_count; // Cycles since row strobe fell
  logic [CW-1:0] ref_count; // Cycles into the current refresh interval
  logic [CW-1:0] pu_count; // Power-up pause counter (CNT_W bits, widened into pu_wide)
  logic [3:0] wake_count; // Wake-up cycles done
  logic ref_pending;
  logic ref_overdue;
  logic open_valid;
  logic [RW-1:0] open_row;
  edc_pkg::edc_req_t cur;
  logic [31:0] pu_wide;

  // Named decodes
  wire [RW-1:0] req_row = req.addr[edc_pkg::ADDR_W-1 -: RW];
  wire [RW-1:0] req_col = req.addr[RW-1:0];
  wire ras_met = (ras_count >= CW'(edc_pkg::RAS_CYC));
  wire ar_met = (ras_count >= CW'(edc_pkg::AR_CYC));
  wire row_acc_met = (ras_count >= CW'(edc_pkg::ACC_ROW_CYC));
  wire page_hit = open_valid && (req_row == open_row);
  wire can_take = (state == S_IDLE || state == S_ROW_OPEN) && !ref_pending && req_valid;
  wire take_hit = can_take && state == S_ROW_OPEN && page_hit;
  wire take_new = can_take && state == S_IDLE;
  wire close_row = state == S_ROW_OPEN && ras_met && (ref_pending || (req_valid && !page_hit));
  wire rfr_fire = (state == S_RFR_SETUP) && tim_done; // Refresh row strobe falls at this edge
  wire at_interval = (ref_count >= CW'(REFRESH_INT_CYC - 1)); // fixed cadence, latency does not drift

  edc_timer #(.W(CW)) u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(tim_load),
    .count(tim_count),
    .done(tim_done)
  );

  // Next state and timer loads
  always_comb begin
    next_state = state;
    tim_load = 1'b0;
    tim_count = '0;
    unique case (state)
      S_POWERUP: if (pu_wide >= POWERUP_CYC) next_state = S_IDLE;
      S_IDLE: begin
        if (tim_done && ref_pending) begin
          next_state = S_RFR_SETUP;
          tim_load = 1'b1;
          tim_count = CW'(edc_pkg::CSR_CYC);
        end else if (tim_done && take_new) begin
          next_state = S_COL_SETUP;
          tim_load = 1'b1;
          tim_count = CW'(edc_pkg::RCD_CYC);
        end
      end
      S_RFR_SETUP: if (tim_done) next_state = S_RFR_ACTIVE;
      S_RFR_ACTIVE: if (ras_met) begin
        next_state = S_PRECHARGE;
        tim_load = 1'b1;
        tim_count = CW'(edc_pkg::RP_CYC);
      end
      S_PRECHARGE: if (tim_done) begin
        next_state = S_IDLE;
      end
      S_ROW_OPEN: begin
        if (close_row) begin
          next_state = S_IDLE;
          tim_load = 1'b1;
          tim_count = CW'(edc_pkg::RP_CYC);
        end else if (take_hit && tim_done) begin
          next_state = S_COL_SETUP;
        end
      end
      S_COL_SETUP: if (tim_done) begin
        next_state = S_COL_ACTIVE;
        tim_load = 1'b1;
        tim_count = CW'(edc_pkg::ACC_COL_CYC);
      end
      S_COL_ACTIVE: if (tim_done && (cur.write || (row_acc_met && ar_met))) begin
        next_state = S_COL_PRE;
        tim_load = 1'b1;
        tim_count = CW'(edc_pkg::CP_CYC);
      end
      S_COL_PRE: next_state = S_ROW_OPEN;
      default: next_state = S_IDLE;
    endcase
  end

  assign pu_wide = 32'(pu_count); // Pause count widened for the parameter compare

  // State and counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_POWERUP;
      ras_count <= '0;
      pu_count <= '0;
    end else begin
      state <= next_state;
      pu_count <= (state == S_POWERUP) ? pu_count + 1'b1 : '0;
      ras_count <= row_strobe_n ? '0 : ((ras_count == '1) ? ras_count : ras_count + 1'b1);
    end
  end

  // Refresh scheduler and wake-up count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_count <= '0;
      ref_pending <= 1'b0;
      ref_overdue <= 1'b0;
      wake_count <= '0;
      init_done <= 1'b0;
    end else begin
      ref_count <= at_interval ? '0 : ref_count + 1'b1;
      if (rfr_fire) begin
        // A new interval landing on the refresh edge still raises a request
        ref_pending <= (wake_count < 4'(edc_pkg::WAKE_CYCLES - 1)) || ref_overdue ||
          (at_interval && init_done);
        wake_count <= (wake_count < 4'(edc_pkg::WAKE_CYCLES)) ? wake_count + 1'b1 : wake_count;
        if (wake_count == 4'(edc_pkg::WAKE_CYCLES - 1)) init_done <= 1'b1;
        if (ref_overdue) begin
          ref_overdue <= 1'b0;
          wake_count <= 4'h1;
          ref_pending <= 1'b1;
          init_done <= 1'b0;
        end
      end else begin
        if (state == S_POWERUP && next_state == S_IDLE) ref_pending <= 1'b1;
        else if (at_interval && init_done) ref_pending <= 1'b1;
        if (at_interval && ref_pending && init_done) ref_overdue <= 1'b1; // a whole interval missed
      end
    end
  end

  // Pins, open row and user answers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      row_strobe_n <= 1'b1;
      low_col_strobe_n <= 1'b1;
      high_col_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_gate_n <= 1'b1;
      mux_address_pins <= 9'h000;
      data_pins_out <= 16'h0000;
      data_pins_oe <= 1'b0;
      open_valid <= 1'b0;
      open_row <= 9'h000;
      cur <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      if (state == S_IDLE && next_state == S_RFR_SETUP) begin
        low_col_strobe_n <= 1'b0; // both lanes low before row strobe
        high_col_strobe_n <= 1'b0;
        data_pins_oe <= 1'b0;
      end
      if (state == S_RFR_SETUP && tim_done) row_strobe_n <= 1'b0;
      if (state == S_RFR_ACTIVE && next_state == S_PRECHARGE) begin
        row_strobe_n <= 1'b1;
        low_col_strobe_n <= 1'b1;
        high_col_strobe_n <= 1'b1;
      end
      if (take_new && tim_done && !(ref_pending)) begin
        mux_address_pins <= req_row;
        row_strobe_n <= 1'b0;
        open_valid <= 1'b1;
        open_row <= req_row;
        cur <= req;
        req_ready <= 1'b1;
      end
      if (state == S_ROW_OPEN && next_state == S_COL_SETUP) begin
        cur <= req;
        req_ready <= 1'b1;
        mux_address_pins <= req_col;
      end
      if (state == S_COL_SETUP && tim_done) begin
        mux_address_pins <= cur.addr[RW-1:0];
        write_strobe_n <= !cur.write; // early write
        output_gate_n <= cur.write;
        data_pins_out <= cur.wdata;
        data_pins_oe <= cur.write;
        low_col_strobe_n <= !cur.lanes[0];
        high_col_strobe_n <= !cur.lanes[1];
      end
      if (state == S_COL_ACTIVE && next_state == S_COL_PRE) begin
        low_col_strobe_n <= 1'b1;
        high_col_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        data_pins_oe <= 1'b0;
        rsp_valid <= 1'b1;
        if (!cur.write) begin
          rsp.rdata <= data_pins_in;
        end
      end
      if (close_row) begin
        row_strobe_n <= 1'b1;
        output_gate_n <= 1'b1;
        open_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/edc_pkg.sv
// Package for the page-mode dynamic memory controller: geometry, timing and user-port structs
package edc_pkg;
  localparam int unsigned ROW_W = 9;
  localparam int unsigned COL_W = 9;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CLK_MHZ = 200;
  // Times in ns unless the name says US or MS, fast grade
  localparam int unsigned ROW_ACTIVE_MIN_NS = 35;
  localparam int unsigned ROW_PRECHARGE_NS = 25;
  localparam int unsigned COL_PRECHARGE_NS = 6;
  localparam int unsigned RCD_MIN_NS = 13;
  localparam int unsigned COL_ADDR_HOLD_FROM_ROW_NS = 30;
  localparam int unsigned ACCESS_FROM_ROW_NS = 35;
  localparam int unsigned ACCESS_FROM_COL_ADDR_NS = 18;
  localparam int unsigned ACCESS_FROM_COL_STROBE_NS = 11;
  localparam int unsigned COL_PULSE_MIN_NS = 6;
  localparam int unsigned CTR_RFR_SETUP_NS = 8;
  localparam int unsigned ROW_ADDR_HOLD_NS = 6;
  localparam int unsigned POWERUP_US = 200;
  localparam int unsigned REFRESH_WINDOW_MS = 8;
  localparam int unsigned REFRESH_ROWS = 512;
  localparam int unsigned WAKE_CYCLES = 8;
  // Least times round up to whole cycles
  function automatic int unsigned ns_cyc(input int unsigned ns);
    ns_cyc = (ns * CLK_MHZ + 999) / 1000;
  endfunction
  localparam int unsigned RAS_CYC = ns_cyc(ROW_ACTIVE_MIN_NS);
  localparam int unsigned RP_CYC = ns_cyc(ROW_PRECHARGE_NS);
  localparam int unsigned CP_CYC = ns_cyc(COL_PRECHARGE_NS);
  localparam int unsigned RCD_CYC = ns_cyc(RCD_MIN_NS);
  localparam int unsigned AR_CYC = ns_cyc(COL_ADDR_HOLD_FROM_ROW_NS);
  localparam int unsigned RAH_CYC = ns_cyc(ROW_ADDR_HOLD_NS);
  localparam int unsigned CSR_CYC = ns_cyc(CTR_RFR_SETUP_NS);
  localparam int unsigned CAS_CYC = ns_cyc(COL_PULSE_MIN_NS);
  localparam int unsigned ACC_ROW_CYC = ns_cyc(ACCESS_FROM_ROW_NS);
  localparam int unsigned ACC_COL_CYC = ns_cyc(ACCESS_FROM_COL_STROBE_NS) + 1;
  // Long counts: defaults for top parameters
  localparam int unsigned POWERUP_CYC = POWERUP_US * CLK_MHZ;
  // Refresh interval rounds down: 8 ms / 512 rows
  localparam int unsigned REFRESH_INT_CYC = (REFRESH_WINDOW_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
  localparam int unsigned CNT_W = 16;
  // User request and answer carriers
  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } edc_req_t;
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } edc_rsp_t;
endpackage

// file: verilog/edc_timer.sv
// Loadable down-counter that flags when a wait has elapsed
`timescale 1ns/1ps
`default_nettype none
module edc_timer #(
  parameter int unsigned W = 16
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic load, // Start a new wait
  input wire logic [W-1:0] count, // Cycles to wait
  output logic done // Wait has elapsed
);
  logic [W-1:0] remain;
  assign done = (remain == '0);
  // Count down to zero and hold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (!done) begin
      remain <= remain - 1'b1;
    end
  end
endmodule
`default_nettype wire
